// ===== logic/trf_defines.vh
// Register map, field positions and reset values of the timestamp readout unit.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
`ifndef TRF_DEFINES_VH
`define TRF_DEFINES_VH

`define TRF_ADDR_W            8
`define TRF_OFS_DELTA_CYCLES  8'h00
`define TRF_OFS_DELTA_TICKS   8'h04
`define TRF_OFS_DELTA_FRAC    8'h08
`define TRF_OFS_CORR_CYCLES   8'h0C
`define TRF_OFS_CORR_TICKS    8'h10
`define TRF_OFS_CORR_FRAC     8'h14
`define TRF_OFS_READOUT_CSR   8'h18
`define TRF_OFS_QUEUE_WORD0   8'h1C
`define TRF_OFS_QUEUE_WORD1   8'h20
`define TRF_OFS_QUEUE_WORD2   8'h24
`define TRF_OFS_QUEUE_WORD3   8'h28
`define TRF_OFS_QUEUE_CSR     8'h2C

`define TRF_CSR_DELTA_READY   0
`define TRF_CSR_DELTA_REQ     1
`define TRF_CSR_SEQ_CLEAR     2
`define TRF_CSR_REF_LO        3
`define TRF_CSR_REF_HI        5
`define TRF_CSR_RAW           6

`define TRF_QCSR_LEVEL_HI     5
`define TRF_QCSR_FULL         16
`define TRF_QCSR_EMPTY        17
`define TRF_QCSR_CLEAR        18

`define TRF_RST_CORR          32'h00000000
`define TRF_RST_REF           3'h0
`define TRF_RST_RAW           1'h0

`define TRF_RESP_OKAY         2'h0
`define TRF_RESP_SLVERR       2'h2

`define TRF_DEPTH             32
`define TRF_LEVEL_W           6
`define TRF_CHAN_COUNT        5

`endif

// ===== logic/trf_stamp_mem.v
// Simple dual-port storage for queued timestamp records.
// Assumes one clock; read data comes from a register, with a write-through
// bypass so that a record written in the same cycle is seen at once.
module trf_stamp_mem #(
  parameter WIDTH  = 128,
  parameter ADDR_W = 5
) (
  input  wire              ref_clk,
  input  wire              wrEn,
  input  wire [ADDR_W-1:0] wrAddr,
  input  wire [WIDTH-1:0]  wrData,
  input  wire [ADDR_W-1:0] rdAddr,
  output reg  [WIDTH-1:0]  rdDataFf
);
  reg [WIDTH-1:0] memArray [0:(1<<ADDR_W)-1];

  always @(posedge ref_clk) begin
    if (wrEn) begin
      memArray[wrAddr] <= wrData;
    end
  end

  // The bypass keeps the head visible in the cycle after a push into an empty queue.
  always @(posedge ref_clk) begin
    if (wrEn && (wrAddr == rdAddr)) begin
      rdDataFf <= wrData;
    end else begin
      rdDataFf <= memArray[rdAddr];
    end
  end
endmodule

// ===== logic/trf_readout_fifo.v
// Readout unit for one timestamp channel: queue, offset correction, delta
// against a reference channel, and an AXI4-Lite register slave.
// Assumes the converter core pushes timestamps synchronous to ref_clk and
// presents the latest timestamp of every channel as steady levels.
//
// The AXI4-Lite register port is this design's own decision.
`include "trf_defines.vh"

// Behaviour
// R1 - Delta word for TAI cycles, signed, read-only at 0x0.
// R2 - Delta word for 8 ns ticks, unsigned, read-only at 0x4.
// R3 - Delta word for fractional part, unsigned, read-only at 0x8.
// R4 - Signed TAI-cycle correction word, read and write at 0xC.
// R5 - Unsigned tick correction word, read and write at 0x10.
// R6 - Unsigned fraction correction word, read and write at 0x14.
// R7 - Control bit 0 reads whether a delta timestamp is ready.
// R8 - Control bit 1 write requests a delta capture; reads zero.
// R9 - Control bit 2 write clears the sequence counter.
// R10 - Control bits 5 to 3 select reference channel 0 to 4.
// R11 - Control bit 6 set gives raw uncorrected timestamps.
// R12 - Head record read as four words at 0x1C to 0x28.
// R13 - Queue status bit 16 reads one when queue is full.
// R14 - Queue status bit 17 reads one when queue is empty.
// R15 - Writing one to queue status bit 18 discards all records.
// R16 - Queue status bits 5 to 0 report the number of records.
// R17 - Interrupt request stays high while the queue holds records.
// R18 - Reading the last data word removes the head record.
// R19 - Delta request captures channel minus reference, then sets ready.
// R20 - Without raw mode, correction words are added before queueing.
module trf_readout_fifo #(
  parameter DEPTH      = `TRF_DEPTH,
  parameter ADDR_W     = 5,
  parameter LEVEL_W    = `TRF_LEVEL_W,
  parameter CHAN_COUNT = `TRF_CHAN_COUNT
) (
  input  wire                     ref_clk,
  input  wire                     rst_b,
  input  wire                     s_axi_awvalid,
  output reg                      s_axi_awready,
  input  wire [`TRF_ADDR_W-1:0]   s_axi_awaddr,
  input  wire [2:0]               s_axi_awprot,
  input  wire                     s_axi_wvalid,
  output reg                      s_axi_wready,
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  output reg  [1:0]               s_axi_bresp,
  input  wire                     s_axi_arvalid,
  output reg                      s_axi_arready,
  input  wire [`TRF_ADDR_W-1:0]   s_axi_araddr,
  input  wire [2:0]               s_axi_arprot,
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  output reg  [31:0]              s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  input  wire                     stampValid,
  output reg                      stampReady,
  input  wire [31:0]              stampCycles,
  input  wire [31:0]              stampTicks,
  input  wire [31:0]              stampFrac,
  input  wire [CHAN_COUNT*32-1:0] refCycles,
  input  wire [CHAN_COUNT*32-1:0] refTicks,
  input  wire [CHAN_COUNT*32-1:0] refFrac,
  output reg                      nonemptyIrq
);

  // Bus handshake state.
  reg  [`TRF_ADDR_W-1:0] awAddrFf;
  reg                    awHeldFf;
  reg  [31:0]            wDataFf;
  reg  [3:0]             wStrbFf;
  reg                    wHeldFf;

  // Software-visible state and the internal delta-pending flag.
  reg  [31:0]            corrCyclesFf;
  reg  [31:0]            corrTicksFf;
  reg  [31:0]            corrFracFf;
  reg  [31:0]            deltaCyclesFf;
  reg  [31:0]            deltaTicksFf;
  reg  [31:0]            deltaFracFf;
  reg                    deltaReadyFf;
  reg                    deltaPendFf;
  reg  [2:0]             deltaRefFf;
  reg                    rawModeFf;
  reg  [31:0]            seqCountFf;

  // Last queued record of this channel, used as the minuend of the delta.
  reg  [31:0]            lastCyclesFf;
  reg  [31:0]            lastTicksFf;
  reg  [31:0]            lastFracFf;

  // Queue pointers and fill level.
  reg  [ADDR_W-1:0]      wrPtrFf;
  reg  [ADDR_W-1:0]      rdPtrFf;
  reg  [LEVEL_W-1:0]     levelFf;

  wire [127:0]           headRecord;

  wire awTake = s_axi_awvalid & s_axi_awready;
  wire wTake  = s_axi_wvalid & s_axi_wready;
  wire arTake = s_axi_arvalid & s_axi_arready;
  wire wrDo   = awHeldFf & wHeldFf;

  wire qEmpty = (levelFf == {LEVEL_W{1'b0}});
  wire qFull  = (levelFf == DEPTH[LEVEL_W-1:0]);

  function [31:0] mergeBytes;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  strb;
    integer      i;
    begin
      mergeBytes = oldVal;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          mergeBytes[i*8 +: 8] = newVal[i*8 +: 8];
        end
      end
    end
  endfunction

  // Decoded write effects.
  wire wrCorrCycles = wrDo & (awAddrFf == `TRF_OFS_CORR_CYCLES);
  wire wrCorrTicks  = wrDo & (awAddrFf == `TRF_OFS_CORR_TICKS);
  wire wrCorrFrac   = wrDo & (awAddrFf == `TRF_OFS_CORR_FRAC);
  wire wrCsrLow     = wrDo & (awAddrFf == `TRF_OFS_READOUT_CSR) & wStrbFf[0];
  wire wrQueueCsr   = wrDo & (awAddrFf == `TRF_OFS_QUEUE_CSR) & wStrbFf[2];
  wire deltaReq     = wrCsrLow & wDataFf[`TRF_CSR_DELTA_REQ];
  wire seqClear     = wrCsrLow & wDataFf[`TRF_CSR_SEQ_CLEAR];
  wire queueClear   = wrQueueCsr & wDataFf[`TRF_QCSR_CLEAR];

  wire wrMapped = (awAddrFf == `TRF_OFS_CORR_CYCLES) | (awAddrFf == `TRF_OFS_CORR_TICKS) |
                  (awAddrFf == `TRF_OFS_CORR_FRAC) | (awAddrFf == `TRF_OFS_READOUT_CSR) |
                  (awAddrFf == `TRF_OFS_QUEUE_CSR);

  // Queue movement.
  wire push = stampValid & stampReady;
  // R18 pop on word3
  wire pop  = arTake & (s_axi_araddr == `TRF_OFS_QUEUE_WORD3) & ~qEmpty;

  // R20 offset correction
  wire [32:0] sumFrac   = {1'b0, stampFrac} + {1'b0, corrFracFf};
  wire [32:0] sumTicks  = {1'b0, stampTicks} + {1'b0, corrTicksFf} + {32'h00000000, sumFrac[32]};
  wire [31:0] sumCycles = stampCycles + corrCyclesFf + {31'h00000000, sumTicks[32]};

  // R11 raw readout bypass
  wire [31:0] inCycles = rawModeFf ? stampCycles : sumCycles;
  wire [31:0] inTicks  = rawModeFf ? stampTicks : sumTicks[31:0];
  wire [31:0] inFrac   = rawModeFf ? stampFrac : sumFrac[31:0];

  reg  [ADDR_W-1:0]  nxt_wrPtr;
  reg  [ADDR_W-1:0]  nxt_rdPtr;
  reg  [LEVEL_W-1:0] nxt_level;

  always @* begin
    nxt_wrPtr = push ? wrPtrFf + {{(ADDR_W-1){1'b0}}, 1'b1} : wrPtrFf;
    // R15 clear discards queue
    if (queueClear) begin
      nxt_rdPtr = wrPtrFf;
      nxt_level = push ? {{(LEVEL_W-1){1'b0}}, 1'b1} : {LEVEL_W{1'b0}};
    end else begin
      nxt_rdPtr = pop ? rdPtrFf + {{(ADDR_W-1){1'b0}}, 1'b1} : rdPtrFf;
      nxt_level = levelFf;
      if (push && !pop) begin
        nxt_level = levelFf + {{(LEVEL_W-1){1'b0}}, 1'b1};
      end else if (pop && !push) begin
        nxt_level = levelFf - {{(LEVEL_W-1){1'b0}}, 1'b1};
      end
    end
  end

  trf_stamp_mem #(
    .WIDTH  (128),
    .ADDR_W (ADDR_W)
  ) u_stamp_mem (
    .ref_clk  (ref_clk),
    .wrEn     (push),
    .wrAddr   (wrPtrFf),
    .wrData   ({seqCountFf, inFrac, inTicks, inCycles}),
    .rdAddr   (nxt_rdPtr),
    .rdDataFf (headRecord)
  );

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      wrPtrFf     <= {ADDR_W{1'b0}};
      rdPtrFf     <= {ADDR_W{1'b0}};
      levelFf     <= {LEVEL_W{1'b0}};
      stampReady  <= 1'b0;
      nonemptyIrq <= 1'b0;
      seqCountFf  <= 32'h00000000;
      lastCyclesFf <= 32'h00000000;
      lastTicksFf <= 32'h00000000;
      lastFracFf  <= 32'h00000000;
    end else begin
      wrPtrFf     <= nxt_wrPtr;
      rdPtrFf     <= nxt_rdPtr;
      levelFf     <= nxt_level;
      // Ready is taken from the next level so a push can never overrun the queue.
      stampReady  <= (nxt_level != DEPTH[LEVEL_W-1:0]);
      // R17 level interrupt request
      nonemptyIrq <= (nxt_level != {LEVEL_W{1'b0}});
      // R9 sequence counter clear
      if (seqClear) begin
        seqCountFf <= 32'h00000000;
      end else if (push) begin
        seqCountFf <= seqCountFf + 32'h00000001;
      end
      if (push) begin
        lastCyclesFf <= inCycles;
        lastTicksFf  <= inTicks;
        lastFracFf   <= inFrac;
      end
    end
  end

  // Reference selection; an index equal to or above the channel count compares against zero.
  wire        refInRange = (deltaRefFf < CHAN_COUNT);
  wire [31:0] selCycles  = refInRange ? refCycles[deltaRefFf*32 +: 32] : 32'h00000000;
  wire [31:0] selTicks   = refInRange ? refTicks[deltaRefFf*32 +: 32] : 32'h00000000;
  wire [31:0] selFrac    = refInRange ? refFrac[deltaRefFf*32 +: 32] : 32'h00000000;

  wire [32:0] difFrac   = {1'b0, lastFracFf} - {1'b0, selFrac};
  wire [32:0] difTicks  = {1'b0, lastTicksFf} - {1'b0, selTicks} - {32'h00000000, difFrac[32]};
  wire [31:0] difCycles = lastCyclesFf - selCycles - {31'h00000000, difTicks[32]};

  // Control and correction registers.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      corrCyclesFf  <= `TRF_RST_CORR;
      corrTicksFf   <= `TRF_RST_CORR;
      corrFracFf    <= `TRF_RST_CORR;
      deltaRefFf    <= `TRF_RST_REF;
      rawModeFf     <= `TRF_RST_RAW;
      deltaPendFf   <= 1'b0;
      deltaReadyFf  <= 1'b0;
      deltaCyclesFf <= 32'h00000000;
      deltaTicksFf  <= 32'h00000000;
      deltaFracFf   <= 32'h00000000;
    end else begin
      // R4 cycle correction word
      if (wrCorrCycles) begin
        corrCyclesFf <= mergeBytes(corrCyclesFf, wDataFf, wStrbFf);
      end
      // R5 tick correction word
      if (wrCorrTicks) begin
        corrTicksFf <= mergeBytes(corrTicksFf, wDataFf, wStrbFf);
      end
      // R6 fraction correction word
      if (wrCorrFrac) begin
        corrFracFf <= mergeBytes(corrFracFf, wDataFf, wStrbFf);
      end
      // R10 reference channel select
      if (wrCsrLow) begin
        deltaRefFf <= wDataFf[`TRF_CSR_REF_HI:`TRF_CSR_REF_LO];
        rawModeFf  <= wDataFf[`TRF_CSR_RAW];
      end
      // R19 two-step delta capture
      deltaPendFf <= deltaReq;
      if (deltaPendFf) begin
        deltaCyclesFf <= difCycles;
        deltaTicksFf  <= difTicks[31:0];
        deltaFracFf   <= difFrac[31:0];
      end
      // R7 ready flag; the capture step wins over a new request's clear.
      if (deltaPendFf) begin
        deltaReadyFf <= 1'b1;
      end else if (deltaReq) begin
        deltaReadyFf <= 1'b0;
      end
    end
  end

  // Read data selection.
  reg [31:0] rdMux;
  reg        rdMapped;

  always @* begin
    rdMux    = 32'h00000000;
    rdMapped = 1'b1;
    case (s_axi_araddr)
      // R1 delta cycles
      `TRF_OFS_DELTA_CYCLES: rdMux = deltaCyclesFf;
      // R2 delta ticks
      `TRF_OFS_DELTA_TICKS:  rdMux = deltaTicksFf;
      // R3 delta fraction
      `TRF_OFS_DELTA_FRAC:   rdMux = deltaFracFf;
      `TRF_OFS_CORR_CYCLES:  rdMux = corrCyclesFf;
      `TRF_OFS_CORR_TICKS:   rdMux = corrTicksFf;
      `TRF_OFS_CORR_FRAC:    rdMux = corrFracFf;
      // R8 command bits read zero
      `TRF_OFS_READOUT_CSR: begin
        rdMux[`TRF_CSR_DELTA_READY] = deltaReadyFf;
        rdMux[`TRF_CSR_REF_HI:`TRF_CSR_REF_LO] = deltaRefFf;
        rdMux[`TRF_CSR_RAW] = rawModeFf;
      end
      // R12 head record words
      `TRF_OFS_QUEUE_WORD0:  rdMux = headRecord[31:0];
      `TRF_OFS_QUEUE_WORD1:  rdMux = headRecord[63:32];
      `TRF_OFS_QUEUE_WORD2:  rdMux = headRecord[95:64];
      `TRF_OFS_QUEUE_WORD3:  rdMux = headRecord[127:96];
      `TRF_OFS_QUEUE_CSR: begin
        // R16 fill level
        rdMux[`TRF_QCSR_LEVEL_HI:0] = levelFf;
        // R13 full flag
        rdMux[`TRF_QCSR_FULL] = qFull;
        // R14 empty flag
        rdMux[`TRF_QCSR_EMPTY] = qEmpty;
      end
      default: rdMapped = 1'b0;
    endcase
  end

  // AXI4-Lite write channel: address and data are taken in either order.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      awAddrFf      <= {`TRF_ADDR_W{1'b0}};
      awHeldFf      <= 1'b0;
      wDataFf       <= 32'h00000000;
      wStrbFf       <= 4'h0;
      wHeldFf       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TRF_RESP_OKAY;
    end else begin
      if (awTake) begin
        awAddrFf <= s_axi_awaddr;
      end
      if (wTake) begin
        wDataFf <= s_axi_wdata;
        wStrbFf <= s_axi_wstrb;
      end
      awHeldFf <= (awHeldFf | awTake) & ~wrDo;
      wHeldFf  <= (wHeldFf | wTake) & ~wrDo;
      if (wrDo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `TRF_RESP_OKAY : `TRF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Readiness drops once a beat is held and stays low until the response is taken.
      s_axi_awready <= ~(awHeldFf | awTake) & ~wrDo & ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_wready  <= ~(wHeldFf | wTake) & ~wrDo & ~(s_axi_bvalid & ~s_axi_bready);
    end
  end

  // AXI4-Lite read channel.
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `TRF_RESP_OKAY;
    end else begin
      if (arTake) begin
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdMux;
        s_axi_rresp   <= rdMapped ? `TRF_RESP_OKAY : `TRF_RESP_SLVERR;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid  <= 1'b0;
          s_axi_arready <= 1'b1;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ===== dv/trf_readout_fifo_assertions.sv
// Checker for the timestamp readout unit: register bus answers and queue status.
// Sees only the unit's ports; attached by the bind below the module.
`include "trf_defines.vh"

module trf_readout_fifo_chk #(
  parameter DEPTH = `TRF_DEPTH
) (
  input wire                   ref_clk,
  input wire                   rst_b,
  input wire                   s_axi_awvalid,
  input wire                   s_axi_awready,
  input wire                   s_axi_wvalid,
  input wire                   s_axi_wready,
  input wire                   s_axi_bvalid,
  input wire                   s_axi_bready,
  input wire                   s_axi_arvalid,
  input wire                   s_axi_arready,
  input wire [`TRF_ADDR_W-1:0] s_axi_araddr,
  input wire                   s_axi_rvalid,
  input wire                   s_axi_rready,
  input wire [31:0]            s_axi_rdata,
  input wire [1:0]             s_axi_rresp,
  input wire                   stampValid,
  input wire                   stampReady,
  input wire                   nonemptyIrq
);
  reg  [`TRF_ADDR_W-1:0] rdAddr_ff;
  wire                   qcsrRd = s_axi_rvalid && rdAddr_ff == `TRF_OFS_QUEUE_CSR;

  // Remembers the read in flight so that each answer is judged by its target.
  always @(posedge ref_clk) begin
    if (s_axi_arvalid && s_axi_arready)
      rdAddr_ff <= s_axi_araddr;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer off time");
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer off time");
  one_resp_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
  rd_refused_a:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  wr_refused_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken early");
  unmapped_rd_a:
    assert property (s_axi_rvalid && rdAddr_ff > `TRF_OFS_QUEUE_CSR
      |-> s_axi_rresp == `TRF_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read answered");
  req_bit_a:
    assert property (s_axi_rvalid && rdAddr_ff == `TRF_OFS_READOUT_CSR
      |-> !s_axi_rdata[`TRF_CSR_DELTA_REQ]) else $error("request bit readable");
  empty_flag_a:
    assert property (qcsrRd |-> s_axi_rdata[17] == (s_axi_rdata[5:0] == 6'h00))
      else $error("empty flag wrong");
  full_flag_a:
    assert property (qcsrRd |-> s_axi_rdata[16] == ({26'h0, s_axi_rdata[5:0]} == DEPTH))
      else $error("full flag wrong");
  irq_push_a:
    assert property (stampValid && stampReady |=> nonemptyIrq)
      else $error("request low after push");
  full_irq_a:
    assert property ($past(rst_b) && !stampReady |-> nonemptyIrq)
      else $error("full without request");

  full_c: cover property (!stampReady && nonemptyIrq);
  pop_c: cover property (s_axi_rvalid && rdAddr_ff == `TRF_OFS_QUEUE_WORD3);
  unmapped_c: cover property (s_axi_rvalid && s_axi_rresp == `TRF_RESP_SLVERR);
endmodule

bind trf_readout_fifo trf_readout_fifo_chk #(.DEPTH(DEPTH)) u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .stampValid(stampValid), .stampReady(stampReady), .nonemptyIrq(nonemptyIrq)
);

// ===== dv/trf_stamp_src.sv
// Stand-in for the converter core: offers this channel's timestamps and
// holds the latest timestamp of every channel as steady levels.
// Assumes its tasks are called from a process timed by ref_clk.
module trf_stamp_src #(
  parameter CHAN_COUNT = 5
) (
  input  wire                      ref_clk,
  input  wire                      stampReady,
  output logic                     stampValid,
  output logic [31:0]              stampCycles,
  output logic [31:0]              stampTicks,
  output logic [31:0]              stampFrac,
  output logic [CHAN_COUNT*32-1:0] refCycles,
  output logic [CHAN_COUNT*32-1:0] refTicks,
  output logic [CHAN_COUNT*32-1:0] refFrac
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    stampValid = 1'b0;
    {stampCycles, stampTicks, stampFrac} = '0;
    {refCycles, refTicks, refFrac} = '0;
  end

  task automatic push(input logic [95:0] s, input int gap);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    stampValid <= 1'b1;
    {stampCycles, stampTicks, stampFrac} <= s;
    do @(posedge ref_clk); while (!stampReady);
    stampValid <= 1'b0;
    // Released lines carry the inverse so stale data never passes for a stamp.
    {stampCycles, stampTicks, stampFrac} <= ~s;
  endtask

  task automatic setRef(input int ch, input logic [95:0] r);
    @(posedge ref_clk);
    refCycles[ch*32 +: 32] <= r[95:64];
    refTicks[ch*32 +: 32] <= r[63:32];
    refFrac[ch*32 +: 32] <= r[31:0];
  endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the timestamp readout unit: registers, queue order,
// correction, delta capture, fill and clear. Assumes the core model beside it.
`include "trf_defines.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic         ref_clk = 1'b0;
  logic         rst_b, awValid, wValid, bReady, arValid, rReady, rawMode;
  logic         awReady, wReady, bValid, arReady, rValid, stampValid, stampReady, irq;
  logic [7:0]   awAddr, arAddr;
  logic [3:0]   wStrb;
  logic [1:0]   bResp, rResp, lastB, lastR;
  logic [31:0]  wData, rData, stampCycles, stampTicks, stampFrac, d, seqCnt;
  logic [159:0] refCycles, refTicks, refFrac;
  logic [95:0]  offs, lastStamp, dv;
  logic [95:0]  refs [5];
  logic [127:0] expQ [$];
  int           mismatches, n_checks;

  trf_readout_fifo dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_bresp(bResp),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_araddr(arAddr),
    .s_axi_arprot(3'h0), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .stampValid(stampValid),
    .stampReady(stampReady), .stampCycles(stampCycles), .stampTicks(stampTicks),
    .stampFrac(stampFrac), .refCycles(refCycles), .refTicks(refTicks),
    .refFrac(refFrac), .nonemptyIrq(irq)
  );

  trf_stamp_src src (
    .ref_clk(ref_clk), .stampReady(stampReady), .stampValid(stampValid),
    .stampCycles(stampCycles), .stampTicks(stampTicks), .stampFrac(stampFrac),
    .refCycles(refCycles), .refTicks(refTicks), .refFrac(refFrac)
  );

  always #5 ref_clk = ~ref_clk;

  // Fraction carries into ticks, ticks into cycles, all plain binary.
  function automatic logic [95:0] corr(input logic [95:0] s);
    logic [32:0] f, t;
    f = s[31:0] + offs[31:0];
    t = s[63:32] + offs[63:32] + f[32];
    return {s[95:64] + offs[95:64] + t[32], t[31:0], f[31:0]};
  endfunction

  function automatic logic [95:0] dlt(input logic [95:0] a, input logic [95:0] b);
    logic [32:0] f, t;
    f = {1'b0, a[31:0]} - b[31:0];
    t = {1'b0, a[63:32]} - b[63:32] - f[32];
    return {a[95:64] - b[95:64] - t[32], t[31:0], f[31:0]};
  endfunction

  function automatic logic [31:0] qcsr(input int n);
    return {14'h0, n == 0, n == `TRF_DEPTH, 10'h0, n[5:0]};
  endfunction

  function automatic logic [31:0] csrv(input logic [2:0] r, input logic raw, req, seq);
    return {25'h0, raw, r, seq, req, 1'b0};
  endfunction

  task automatic axW(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge ref_clk);
    {awValid, wValid, bReady} <= 3'h7;
    {awAddr, wData, wStrb} <= {a, v, s};
    do begin
      @(posedge ref_clk);
      if (awReady && pa) begin
        awValid <= 1'b0;
        pa = 1'b0;
      end
      if (wReady && pw) begin
        wValid <= 1'b0;
        pw = 1'b0;
      end
    end while (pa || pw);
    while (!bValid) @(posedge ref_clk);
    lastB = bResp;
    bReady <= 1'b0;
  endtask

  task automatic chkR(input logic [7:0] a, input logic [1:0] er,
                      input logic [31:0] e, input logic [31:0] m);
    @(posedge ref_clk);
    {arValid, rReady, arAddr} <= {2'h3, a};
    do @(posedge ref_clk); while (!arReady);
    arValid <= 1'b0;
    do @(posedge ref_clk); while (!rValid);
    {d, lastR} = {rData, rResp};
    rReady <= 1'b0;
    `CHK({lastR, d & m}, {er, e & m})
  endtask

  task automatic pushOne(input int gap);
    logic [95:0] s;
    s = {$urandom, $urandom, $urandom};
    src.push(s, gap);
    lastStamp = rawMode ? s : corr(s);
    expQ.push_back({lastStamp, seqCnt});
    seqCnt++;
  endtask

  task automatic popCheck;
    logic [127:0] e;
    e = expQ.pop_front();
    for (int i = 0; i < 4; i++)
      chkR(8'h1C + 8'(4 * i), 2'h0, e[127 - 32 * i -: 32], '1);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    report_and_stop;
  end

  initial begin
    {rst_b, awValid, wValid, bReady, arValid, rReady, rawMode} = '0;
    {awAddr, arAddr, wData, wStrb, offs, seqCnt} = '0;
    void'($urandom(78));
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chkR(8'h2C, 2'h0, qcsr(0), 32'h0003003F);
    chkR(8'h18, 2'h0, 32'h0, 32'h7B);
    `CHK(irq, 1'b0)
    for (int i = 0; i < 3; i++) begin
      offs[95 - 32 * i -: 32] = $urandom;
      axW(8'h0C + 8'(4 * i), offs[95 - 32 * i -: 32], 4'hF);
    end
    axW(8'h10, 32'hA5A55A5A, 4'h3);
    `CHK(lastB, `TRF_RESP_OKAY)
    offs[47:32] = 16'h5A5A;
    for (int i = 0; i < 3; i++)
      chkR(8'h0C + 8'(4 * i), 2'h0, offs[95 - 32 * i -: 32], '1);
    axW(8'h00, $urandom, 4'hF);
    chkR(8'h00, 2'h0, 32'h0, '1);
    axW(8'h30, 32'h1, 4'hF);
    `CHK(lastB, `TRF_RESP_SLVERR)
    chkR(8'h30, `TRF_RESP_SLVERR, 32'h0, '1);
    for (int i = 0; i < 3; i++)
      pushOne(i);
    chkR(8'h2C, 2'h0, qcsr(3), 32'h0003003F);
    `CHK(irq, 1'b1)
    repeat (3) popCheck;
    `CHK(irq, 1'b0)
    axW(8'h18, csrv(0, 1, 0, 0), 4'h1);
    rawMode = 1'b1;
    pushOne(0);
    popCheck;
    for (int ch = 0; ch < 5; ch++) begin
      refs[ch] = {$urandom, $urandom, $urandom};
      src.setRef(ch, refs[ch]);
    end
    for (int ch = 0; ch < 5; ch++) begin
      axW(8'h18, csrv(3'(ch), ch[0], 1'b1, 1'b0), 4'h1);
      chkR(8'h18, 2'h0, csrv(3'(ch), ch[0], 0, 0) | 32'h1, 32'h7B);
      dv = dlt(lastStamp, refs[ch]);
      for (int i = 0; i < 3; i++)
        chkR(8'h00 + 8'(4 * i), 2'h0, dv[95 - 32 * i -: 32], '1);
    end
    // An index beyond the last channel compares against zero.
    axW(8'h18, csrv(3'h7, 1'b0, 1'b1, 1'b0), 4'h1);
    dv = dlt(lastStamp, 96'h0);
    chkR(8'h00, 2'h0, dv[95:64], '1);
    rawMode = 1'b0;
    axW(8'h18, csrv(0, 0, 0, 1), 4'h1);
    seqCnt = 0;
    pushOne(1);
    axW(8'h2C, 32'h0, 4'hF);
    chkR(8'h2C, 2'h0, qcsr(1), 32'h0003003F);
    popCheck;
    repeat (`TRF_DEPTH) pushOne(0);
    chkR(8'h2C, 2'h0, qcsr(`TRF_DEPTH), 32'h0003003F);
    `CHK(stampReady, 1'b0)
    axW(8'h2C, 32'h00040000, 4'h4);
    expQ.delete();
    chkR(8'h2C, 2'h0, qcsr(0), 32'h0003003F);
    `CHK(irq, 1'b0)
    for (int k = 0; k < 40; k++) begin
      if ($urandom % 2 && expQ.size() < `TRF_DEPTH)
        pushOne($urandom % 3);
      else if (expQ.size() > 0)
        popCheck;
    end
    report_and_stop;
  end
endmodule
